/* File: bench/ibcs_asserts.sv */
// Purpose: port checks of the bus cycle sequencer
// Assumes: op held by the driver while busy
// Notes:   strobe vectors follow ibcs_strobes_t order
`timescale 1ns/100ps
`default_nettype none
module ibcs_asserts (
	// clock and reset
	input wire logic			clk,
	input wire logic			reset,
	// observed ports
	input wire ibcs_pkg::ibcs_op_t		op,
	input wire logic [15:0]			address,
	input wire logic			addressValid,
	input wire logic			dataEnable,
	input wire ibcs_pkg::ibcs_strobes_t	strobes,
	input wire logic			busy,
	input wire logic			done,
	input wire logic			interruptSampleEnable,
	input wire ibcs_pkg::ibcs_cycle_t	cycleKind
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_f1; cycleKind == ibcs_pkg::CY_FETCH1 |-> strobes == 7'h2a; endproperty
	a_f1: assert property (p_f1) else $error("fetch1 strobes");
	property p_f2; cycleKind == ibcs_pkg::CY_FETCH2 |-> strobes == 7'h2b; endproperty
	a_f2: assert property (p_f2) else $error("fetch2 strobes");
	property p_rd; cycleKind inside {ibcs_pkg::CY_OPER_LO, ibcs_pkg::CY_OPER_HI,
		ibcs_pkg::CY_MEM_RD} |-> strobes == 7'h2f && addressValid; endproperty
	a_rd: assert property (p_rd) else $error("read strobes wrong");
	property p_int; cycleKind == ibcs_pkg::CY_INTERNAL |->
		strobes == 7'h7f && !addressValid && !dataEnable; endproperty
	a_int: assert property (p_int) else $error("internal state not idle");
	property p_wr; cycleKind == ibcs_pkg::CY_MEM_WR |-> strobes == 7'h4f && dataEnable; endproperty
	a_wr: assert property (p_wr) else $error("write strobes");
	property p_io; cycleKind == ibcs_pkg::CY_IO_WR |-> strobes == 7'h57 && dataEnable; endproperty
	a_io: assert property (p_io) else $error("io strobes");
	property p_pz; cycleKind == ibcs_pkg::CY_IO_WR && op inside {ibcs_pkg::OP_PAGE_ZERO_OUTPUT,
		ibcs_pkg::OP_PAGE_ZERO_BLOCK, ibcs_pkg::OP_PAGE_ZERO_BLOCK_REP} |->
		address[15:8] == 8'h00; endproperty
	a_pz: assert property (p_pz) else $error("page zero upper byte set");
	property p_len; $changed(cycleKind) && cycleKind inside {ibcs_pkg::CY_FETCH1,
		ibcs_pkg::CY_FETCH2, ibcs_pkg::CY_MEM_RD, ibcs_pkg::CY_MEM_WR, ibcs_pkg::CY_IO_WR}
		|=> $stable(cycleKind) [*2]; endproperty
	a_len: assert property (p_len) else $error("bus cycle short");
	property p_ise; interruptSampleEnable |-> done && op != ibcs_pkg::OP_LD_A_VEC; endproperty
	a_ise: assert property (p_ise) else $error("interrupt sampled wrongly");
	property p_rst; disable iff (1'b0) reset |=> strobes == 7'h7f && !busy; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind ibcs_sequencer ibcs_asserts chk_u (.*);
`default_nettype wire

/* File: bench/ibcs_bus_partner.sv */
// Purpose: memory and io devices on the system bus
// Assumes: one bus cycle per change of kind or address
// Notes:   logs the first two data accesses of an instruction
`timescale 1ns/100ps
`default_nettype none
module ibcs_bus_partner (
	// clock and reset
	input wire logic			clk,
	input wire logic			reset,
	// bus seen from the sequencer
	input wire logic			clear,
	input wire logic [1:0]			waitLen,
	input wire logic [15:0]			address,
	input wire ibcs_pkg::ibcs_strobes_t	strobes,
	input wire ibcs_pkg::ibcs_cycle_t	cycleKind,
	// answers
	output logic				waitN,
	output logic [15:0]			firstAddr,
	output logic [15:0]			secondAddr,
	output logic [3:0]			accessCount
);
	ibcs_pkg::ibcs_cycle_t	lastKind;
	logic [15:0]		lastAddr;
	logic [1:0]		waitLeft;
	wire logic	busOn = !(strobes.memoryEnableN && strobes.ioEnableN);
	wire logic	newCycle = busOn && (cycleKind != lastKind || address != lastAddr);
	wire logic	dataCycle = cycleKind inside {ibcs_pkg::CY_MEM_RD, ibcs_pkg::CY_MEM_WR,
		ibcs_pkg::CY_IO_WR};
	// slow device: wait held from the start of each bus cycle
	assign waitN = (waitLeft == 2'h0);
	always @(posedge clk) begin
		lastKind <= cycleKind;
		lastAddr <= address;
		if (reset)
			waitLeft <= 2'h0;
		else if (newCycle)
			waitLeft <= waitLen;
		else if (waitLeft != 2'h0)
			waitLeft <= waitLeft - 2'h1;
		if (clear)
			accessCount <= 4'h0;
		else if (newCycle && dataCycle) begin
			accessCount <= accessCount + 4'h1;
			if (accessCount == 4'h0)
				firstAddr <= address;
			if (accessCount == 4'h1)
				secondAddr <= address;
		end
	end
endmodule
`default_nettype wire

/* File: bench/instruction_bus_cycle_sequencer_test.sv */
// Purpose: self-checking bench of the bus cycle sequencer
// Assumes: counts are machine cycles, bus cycles three clocks
// Notes:   row counts: fetch1 fetch2 operand internal read write io
`timescale 1ns/100ps
`default_nettype none
module instruction_bus_cycle_sequencer_test;
	typedef struct packed {
		ibcs_pkg::ibcs_op_t	op;
		logic [1:0]		cc;
		logic [27:0]		cnt;
		logic [15:0]		a0;
		logic [15:0]		a1;
	} ibcs_row_t;
	localparam ibcs_row_t ROWS [18] = '{
		'{ibcs_pkg::OP_NOP, 2'h0, 28'h1000000, 16'h0, 16'h0},
		'{ibcs_pkg::OP_MULTIPLY, 2'h0, 28'h110b000, 16'h0, 16'h0},
		'{ibcs_pkg::OP_LD_HL_MN, 2'h0, 28'h1020200, 16'h4000, 16'h4001},
		'{ibcs_pkg::OP_LD_MN_WW_PFX, 2'h0, 28'h1121020, 16'h4000, 16'h4001},
		'{ibcs_pkg::OP_PAGE_ZERO_OUTPUT, 2'h0, 28'h1111001, 16'h0012, 16'h0},
		'{ibcs_pkg::OP_PAGE_ZERO_BLOCK, 2'h0, 28'h1102101, 16'h2000, 16'h0055},
		'{ibcs_pkg::OP_PAGE_ZERO_BLOCK_REP, 2'h1, 28'h1102101, 16'h2000, 16'h0055},
		'{ibcs_pkg::OP_BLOCK_MOVE_REPEAT, 2'h0, 28'h1102110, 16'h2000, 16'h3000},
		'{ibcs_pkg::OP_BLOCK_MOVE_REPEAT, 2'h1, 28'h1100110, 16'h2000, 16'h3000},
		'{ibcs_pkg::OP_BLOCK_OUTPUT_REPEAT, 2'h0, 28'h1102101, 16'h2000, 16'h0455},
		'{ibcs_pkg::OP_BLOCK_OUTPUT, 2'h0, 28'h1100101, 16'h2000, 16'h0455},
		'{ibcs_pkg::OP_POP, 2'h0, 28'h1000200, 16'h8000, 16'h8001},
		'{ibcs_pkg::OP_PUSH, 2'h0, 28'h1002020, 16'h7fff, 16'h7ffe},
		'{ibcs_pkg::OP_RET_COND, 2'h0, 28'h1002000, 16'h0, 16'h0},
		'{ibcs_pkg::OP_RET_COND, 2'h2, 28'h1001200, 16'h8000, 16'h8001},
		'{ibcs_pkg::OP_LD_SP_IDX, 2'h0, 28'h1101000, 16'h0, 16'h0},
		'{ibcs_pkg::OP_LD_A_VEC, 2'h0, 28'h1100000, 16'h0, 16'h0},
		'{ibcs_pkg::OP_RET, 2'h0, 28'h1000200, 16'h8000, 16'h8001}};
	localparam int KMAP [7] = '{0, 1, 2, 4, 5, 6, 7};
	logic				clk = 1'h0;
	logic				reset = 1'h1;
	logic				start = 1'h0;
	logic				condTrue = 1'h0;
	logic				countZero = 1'h0;
	logic [1:0]			waitLen = 2'h0;
	ibcs_pkg::ibcs_op_t		op = ibcs_pkg::OP_NOP;
	ibcs_pkg::ibcs_regs_t		regs = '{16'h1000, 16'h8000, 16'h2000, 16'h3000,
		16'h0455, 16'h4000, 8'h12};
	logic				waitN;
	logic [15:0]			address;
	logic				addressValid;
	logic				dataEnable;
	ibcs_pkg::ibcs_strobes_t	strobes;
	logic				busy;
	logic				done;
	logic				ise;
	ibcs_pkg::ibcs_cycle_t		cycleKind;
	logic [15:0]			firstAddr;
	logic [15:0]			secondAddr;
	logic [3:0]			accessCount;
	logic [7:0]			meas [16];
	logic				iseSeen;
	int				failures = 0;
	int				numChecks = 0;
	int				cyc = 0;
	ibcs_sequencer dut_u (.*, .interruptSampleEnable(ise));
	ibcs_bus_partner bus_u (.*, .clear(start && !busy));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			failures++;
			conclude();
		end
		if (start && !busy) begin
			foreach (meas[i]) meas[i] <= 8'h00;
			iseSeen <= 1'h0;
		end else begin
			if (cycleKind != ibcs_pkg::CY_DONE)
				meas[cycleKind] <= meas[cycleKind] + 8'h01;
			if (ise)
				iseSeen <= 1'h1;
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		numChecks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		if (failures == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic run(input ibcs_row_t r, input logic [1:0] w, input int hold);
		int n;
		logic [15:0] e;
		logic [15:0] g;
		n = 0;
		op <= r.op;
		{condTrue, countZero} <= r.cc;
		waitLen <= w;
		start <= 1'h1;
		repeat (hold) @(posedge clk);
		start <= 1'h0;
		do @(negedge clk); while (done !== 1'h1 && ++n < 500);
		if (n >= 500) failures++;
		repeat (3) @(posedge clk);
		for (int k = 0; k < 7; k++) begin
			e = 16'(r.cnt[27 - 4 * k -: 4]) * ((k == 3) ? 16'h1 : 16'h3);
			g = 16'(meas[KMAP[k]]) + ((k == 2) ? 16'(meas[3]) : 16'h0);
			if (w == 2'h0)
				chk("cycle clocks", e, g);
		end
		e = 16'(r.cnt[11:8]) + 16'(r.cnt[7:4]) + 16'(r.cnt[3:0]);
		chk("accesses", e, 16'(accessCount));
		if (e > 0) chk("first address", r.a0, firstAddr);
		if (e > 1) chk("second address", r.a1, secondAddr);
		chk("interrupt sample", 16'(r.op != ibcs_pkg::OP_LD_A_VEC), 16'(iseSeen));
		if (w != 2'h0) chk("stretched read", 16'h1, 16'(meas[5] > 8'h06));
	endtask
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk("reset strobes", 16'h007f, 16'(strobes));
		chk("reset kind", 16'(ibcs_pkg::CY_DONE), 16'(cycleKind));
		@(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		foreach (ROWS[i]) run(ROWS[i], 2'h0, 1);
		run(ROWS[11], 2'h3, 1);
		// start held while busy must not launch a second instruction
		run(ROWS[0], 2'h0, 3);
		op <= ibcs_pkg::OP_MULTIPLY;
		start <= 1'h1;
		@(posedge clk);
		start <= 1'h0;
		repeat (8) @(posedge clk);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("mid reset busy", 16'h0, 16'(busy));
		chk("mid reset strobes", 16'h007f, 16'(strobes));
		@(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		run(ROWS[4], 2'h0, 1);
		conclude();
	end
endmodule
`default_nettype wire

/* File: common/ibcs_defines.svh */
// Purpose: constants of the bus cycle sequencer
// Assumes: 40 MHz processor clock
// Notes:   strobe levels are active low except status
`ifndef IBCS_DEFINES_SVH
`define IBCS_DEFINES_SVH

`define IBCS_ADDR_W        16
`define IBCS_MULT_INTERNAL 4'hb
`define IBCS_PAGE_ZERO     8'h00
`define IBCS_TSTATES       2'h3
`define IBCS_ISTATE_CYC    1

`endif

/* File: common/ibcs_pkg.sv */
// Purpose: types of the bus cycle sequencer
// Assumes: nothing
// Notes:   one step of an instruction is one machine cycle
package ibcs_pkg;

	typedef enum logic [4:0] {
		OP_NOP                   = 5'h00,
		OP_NEG                   = 5'h01,
		OP_LD_A_MN               = 5'h02,
		OP_LD_MN_A               = 5'h03,
		OP_LD_WW_IMM             = 5'h04,
		OP_LD_HL_MN              = 5'h05,
		OP_LD_WW_MN_PFX          = 5'h06,
		OP_LD_MN_HL              = 5'h07,
		OP_LD_MN_WW_PFX          = 5'h08,
		OP_LD_SP_IDX             = 5'h09,
		OP_LD_A_VEC              = 5'h0a,
		OP_BLOCK_MOVE            = 5'h0b,
		OP_BLOCK_MOVE_REPEAT     = 5'h0c,
		OP_MULTIPLY              = 5'h0d,
		OP_OUT_IMM               = 5'h0e,
		OP_OUT_C                 = 5'h0f,
		OP_PAGE_ZERO_OUTPUT      = 5'h10,
		OP_PAGE_ZERO_BLOCK       = 5'h11,
		OP_PAGE_ZERO_BLOCK_REP   = 5'h12,
		OP_BLOCK_OUTPUT          = 5'h13,
		OP_BLOCK_OUTPUT_REPEAT   = 5'h14,
		OP_POP                   = 5'h15,
		OP_POP_IDX               = 5'h16,
		OP_PUSH                  = 5'h17,
		OP_PUSH_IDX              = 5'h18,
		OP_RET                   = 5'h19,
		OP_RET_COND              = 5'h1a,
		OP_RET_INTERRUPT         = 5'h1b,
		OP_LD_A_IND              = 5'h1c,
		OP_LD_IND_A              = 5'h1d
	} ibcs_op_t;

	typedef enum logic [3:0] {
		CY_FETCH1   = 4'h0,
		CY_FETCH2   = 4'h1,
		CY_OPER_LO  = 4'h2,
		CY_OPER_HI  = 4'h3,
		CY_INTERNAL = 4'h4,
		CY_MEM_RD   = 4'h5,
		CY_MEM_WR   = 4'h6,
		CY_IO_WR    = 4'h7,
		CY_DONE     = 4'h8
	} ibcs_cycle_t;

	typedef enum logic [2:0] {
		AS_PC      = 3'h0,
		AS_DIRECT  = 3'h1,
		AS_PTR     = 3'h2,
		AS_DEST    = 3'h3,
		AS_STACK   = 3'h4,
		AS_COUNT   = 3'h5,
		AS_PZ_IMM  = 3'h6,
		AS_PZ_C    = 3'h7
	} ibcs_addr_src_t;

	// one machine cycle: kind, address source, offset added to it or, with negOffset, subtracted
	typedef struct packed {
		ibcs_cycle_t    kind;
		ibcs_addr_src_t src;
		logic [1:0]     offset;
		logic           negOffset;
	} ibcs_step_t;

	typedef struct packed {
		logic readN;
		logic writeN;
		logic memoryEnableN;
		logic ioEnableN;
		logic fetchStrobeN;
		logic haltN;
		logic firstFetchStatus;
	} ibcs_strobes_t;

	typedef struct packed {
		logic [15:0] programCounter;
		logic [15:0] stackPointer;
		logic [15:0] pointerPair;
		logic [15:0] destPair;
		logic [15:0] countPortPair;
		logic [15:0] directAddress;
		logic [7:0]  portNumber;
	} ibcs_regs_t;

endpackage

/* File: verilog/ibcs_sequencer.sv */
// Purpose: per instruction bus cycle sequencer
// Assumes: decoded instruction and register values supplied by the core
// Notes:   outputs registered; data bus float shown by dataEnable low
`timescale 1ns/100ps
`default_nettype none
`include "ibcs_defines.svh"

// Functional notes
// - first opcode fetch: read, memory, fetch strobe low; write, io, halt high; status low.
// - second opcode fetch: same strobes as first fetch but status high.
// - operand fetch is memory read, fetch strobe high, status high, low byte first.
// - multiply runs two fetches then eleven internal states, bus idle.
// - 16-bit direct load reads address then address plus one.
// - 16-bit direct store: one internal state, low byte at address, high at plus one.
// - page-zero output: port fetch, internal state, io write with zero upper byte.
// - page-zero block output: internal, read pointer pair, io write, internal.
// - repeating page-zero output adds internal states while count nonzero.
// - block move reads source then writes destination; repeat adds two internals.
// - block output reads pointer then io writes to count/port pair; repeat adds two.
// - pop and return read stack pointer then stack pointer plus one.
// - push: two internal states, high byte at minus one, low at minus two.
// - false conditional return: two internal states only, no stack reads.
// - true conditional return: one internal state then two stack reads.
// - early silicon returns from interrupt: two fetches then two stack reads.
// - later silicon does not sample interrupts while copying vector or refresh.
// - stack pointer from index register: two fetches then one internal state.
module ibcs_sequencer #(
	parameter int unsigned ADDR_W      = `IBCS_ADDR_W,
	parameter bit          LATE_SILICON = 1'b1
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// instruction request
	input  wire logic                        start,
	input  wire ibcs_pkg::ibcs_op_t          op,
	input  wire logic                        condTrue,
	input  wire logic                        countZero,
	input  wire ibcs_pkg::ibcs_regs_t        regs,
	// wait pin from the bus
	input  wire logic                        waitN,
	// bus pins
	output logic [ADDR_W-1:0]                address,
	output logic                             addressValid,
	output logic                             dataEnable,
	output var ibcs_pkg::ibcs_strobes_t      strobes,
	// progress
	output logic                             busy,
	output logic                             done,
	output logic                             interruptSampleEnable,
	output var ibcs_pkg::ibcs_cycle_t        cycleKind
);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RUN   = 2'b01,
		ST_LAST  = 2'b10
	} ibcs_fsm_t;

	ibcs_fsm_t              state;
	ibcs_fsm_t              next_state;
	ibcs_pkg::ibcs_op_t     curOp;
	ibcs_pkg::ibcs_regs_t   curRegs;
	logic                   curCond;
	logic                   curZero;
	logic [3:0]             index;
	logic [3:0]             next_index;
	ibcs_pkg::ibcs_step_t   step;
	logic                   waitMeta;
	logic                   waitSync;
	logic                   lastState;
	logic [1:0]             tState;
	logic                   stepStart;
	logic                   isBus;
	logic [15:0]            baseAddr;
	logic [15:0]            stepAddr;
	logic [15:0]            offsetWide;
	ibcs_pkg::ibcs_strobes_t next_strobes;
	logic                   next_addressValid;
	logic                   next_dataEnable;
	logic                   noSample;

	// pin waits pass two flops before anyone looks at them
	always_ff @(posedge clk) begin
		if (reset) begin
			waitMeta <= 1'b0;
			waitSync <= 1'b0;
		end else begin
			waitMeta <= !waitN;
			waitSync <= waitMeta;
		end
	end

	ibcs_step_rom u_rom (
		.op        (curOp),
		.index     (index),
		.condTrue  (curCond),
		.countZero (curZero),
		.step      (step)
	);

	assign isBus = step.kind != ibcs_pkg::CY_INTERNAL && step.kind != ibcs_pkg::CY_DONE;

	ibcs_state_timer u_timer (
		.clk         (clk),
		.reset       (reset),
		.start       (stepStart),
		.busCycle    (isBus),
		.waitRequest (waitSync),
		.lastState   (lastState),
		.tState      (tState)
	);

	// stepStart marks only the first machine cycle, on entry from idle; the timer restarts itself after each finished one
	assign stepStart = state == ST_IDLE && start;

	assign next_index = lastState ? index + 4'h1 : index;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (start) next_state = ST_RUN;
			ST_RUN: if (step.kind == ibcs_pkg::CY_DONE) next_state = ST_LAST;
			ST_LAST: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state   <= ST_IDLE;
			index   <= 4'h0;
			curOp   <= ibcs_pkg::OP_NOP;
			curRegs <= '0;
			curCond <= 1'b0;
			curZero <= 1'b0;
		end else begin
			state <= next_state;
			if (stepStart) begin
				index   <= 4'h0;
				curOp   <= op;
				curRegs <= regs;
				curCond <= condTrue;
				curZero <= countZero;
			end else if (state == ST_RUN) begin
				index <= next_index;
			end
		end
	end

	// address source selection
	assign baseAddr =
		(step.src == ibcs_pkg::AS_DIRECT) ? curRegs.directAddress :
		(step.src == ibcs_pkg::AS_PTR && (curOp == ibcs_pkg::OP_LD_A_IND
			|| curOp == ibcs_pkg::OP_LD_IND_A)) ? curRegs.destPair :
		(step.src == ibcs_pkg::AS_PTR) ? curRegs.pointerPair :
		(step.src == ibcs_pkg::AS_DEST) ? curRegs.destPair :
		(step.src == ibcs_pkg::AS_STACK) ? curRegs.stackPointer :
		(step.src == ibcs_pkg::AS_COUNT && curOp == ibcs_pkg::OP_OUT_IMM)
			? {curRegs.countPortPair[15:8], curRegs.portNumber} :
		(step.src == ibcs_pkg::AS_COUNT) ? curRegs.countPortPair :
		(step.src == ibcs_pkg::AS_PZ_IMM) ? {`IBCS_PAGE_ZERO, curRegs.portNumber} :
		(step.src == ibcs_pkg::AS_PZ_C)
			? {`IBCS_PAGE_ZERO, curRegs.countPortPair[7:0]} :
		curRegs.programCounter + {12'h000, index};
	assign offsetWide = {14'h0000, step.offset};
	// plus one for second bytes, minus one or two for pushes
	assign stepAddr = step.negOffset ? baseAddr - offsetWide : baseAddr + offsetWide;

	// strobe levels per cycle kind
	always_comb begin
		next_strobes      = '1;
		next_addressValid = 1'b0;
		next_dataEnable   = 1'b0;
		case (step.kind)
			ibcs_pkg::CY_FETCH1: begin
				next_strobes      = 7'b0101010;
				next_addressValid = 1'b1;
			end
			ibcs_pkg::CY_FETCH2: begin
				next_strobes      = 7'b0101011;
				next_addressValid = 1'b1;
			end
			ibcs_pkg::CY_OPER_LO, ibcs_pkg::CY_OPER_HI, ibcs_pkg::CY_MEM_RD: begin
				next_strobes      = 7'b0101111;
				next_addressValid = 1'b1;
			end
			ibcs_pkg::CY_MEM_WR: begin
				next_strobes      = 7'b1001111;
				next_addressValid = 1'b1;
				next_dataEnable   = 1'b1;
			end
			ibcs_pkg::CY_IO_WR: begin
				next_strobes      = 7'b1010111;
				next_addressValid = 1'b1;
				next_dataEnable   = 1'b1;
			end
			default: begin
				// internal states: bus idle, data floating, all inactive
				next_strobes      = '1;
			end
		endcase
	end

	// later silicon must not take an interrupt while copying vector or refresh
	assign noSample = LATE_SILICON && curOp == ibcs_pkg::OP_LD_A_VEC;

	always_ff @(posedge clk) begin
		if (reset) begin
			address               <= '0;
			addressValid          <= 1'b0;
			dataEnable            <= 1'b0;
			strobes               <= '1;
			busy                  <= 1'b0;
			done                  <= 1'b0;
			interruptSampleEnable <= 1'b0;
			cycleKind             <= ibcs_pkg::CY_DONE;
		end else begin
			address               <= ADDR_W'(stepAddr);
			addressValid          <= state == ST_RUN && next_addressValid;
			dataEnable            <= state == ST_RUN && next_dataEnable;
			strobes               <= (state == ST_RUN) ? next_strobes : '1;
			busy                  <= next_state != ST_IDLE;
			done                  <= state == ST_LAST;
			interruptSampleEnable <= state == ST_LAST && !noSample;
			cycleKind             <= (state == ST_RUN) ? step.kind : ibcs_pkg::CY_DONE;
		end
	end

endmodule

`default_nettype wire

/* File: verilog/ibcs_state_timer.sv */
// Purpose: times the T states of one machine cycle
// Assumes: wait requests come already synchronised
// Notes:   bus cycles are T1 T2 T3 with waits after T2
`timescale 1ns/100ps
`default_nettype none
`include "ibcs_defines.svh"

module ibcs_state_timer #(
	parameter int unsigned INTERNAL_CYCLES = `IBCS_ISTATE_CYC
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// control
	input  wire logic start,
	input  wire logic busCycle,
	input  wire logic waitRequest,
	// status
	output logic      lastState,
	output logic [1:0] tState
);

	logic [1:0] count;
	logic [1:0] target;
	logic       holdWait;

	assign target    = busCycle ? `IBCS_TSTATES - 2'h1 : 2'(INTERNAL_CYCLES - 1);
	// waits stretch T2 only, never T1 or T3
	assign holdWait  = busCycle && waitRequest && count == 2'h1;
	assign lastState = !start && count == target && !holdWait;
	assign tState    = count;

	always_ff @(posedge clk) begin
		if (reset || start || lastState) count <= 2'h0;
		else if (!holdWait) count <= count + 2'h1;
	end

endmodule

`default_nettype wire

/* File: verilog/ibcs_step_rom.sv */
// Purpose: machine cycle sequence of each instruction
// Assumes: step index counts machine cycles from the first fetch
// Notes:   ends each list with CY_DONE; repeat tails are chosen here from countZero
`timescale 1ns/100ps
`default_nettype none
`include "ibcs_defines.svh"

module ibcs_step_rom (
	// selection
	input  wire ibcs_pkg::ibcs_op_t  op,
	input  wire logic [3:0]          index,
	input  wire logic                condTrue,
	input  wire logic                countZero,
	// result
	output var ibcs_pkg::ibcs_step_t  step
);

	function automatic ibcs_pkg::ibcs_step_t mk(ibcs_pkg::ibcs_cycle_t k,
			ibcs_pkg::ibcs_addr_src_t s, logic [1:0] o, logic n);
		mk = '{kind: k, src: s, offset: o, negOffset: n};
	endfunction

	// program counter source, no offset
	localparam ibcs_pkg::ibcs_step_t F1 = {ibcs_pkg::CY_FETCH1, 6'h00};
	localparam ibcs_pkg::ibcs_step_t F2 = {ibcs_pkg::CY_FETCH2, 6'h00};
	localparam ibcs_pkg::ibcs_step_t OL = {ibcs_pkg::CY_OPER_LO, 6'h00};
	localparam ibcs_pkg::ibcs_step_t OH = {ibcs_pkg::CY_OPER_HI, 6'h00};
	localparam ibcs_pkg::ibcs_step_t TI = {ibcs_pkg::CY_INTERNAL, 6'h00};
	localparam ibcs_pkg::ibcs_step_t DN = {ibcs_pkg::CY_DONE, 6'h00};

	ibcs_pkg::ibcs_step_t rdDirect;
	ibcs_pkg::ibcs_step_t rdDirect1;
	ibcs_pkg::ibcs_step_t wrDirect;
	ibcs_pkg::ibcs_step_t wrDirect1;
	ibcs_pkg::ibcs_step_t rdPtr;
	ibcs_pkg::ibcs_step_t rdStack;
	ibcs_pkg::ibcs_step_t rdStack1;
	ibcs_pkg::ibcs_step_t wrStackM1;
	ibcs_pkg::ibcs_step_t wrStackM2;

	assign rdDirect  = mk(ibcs_pkg::CY_MEM_RD, ibcs_pkg::AS_DIRECT, 2'h0, 1'b0);
	assign rdDirect1 = mk(ibcs_pkg::CY_MEM_RD, ibcs_pkg::AS_DIRECT, 2'h1, 1'b0);
	assign wrDirect  = mk(ibcs_pkg::CY_MEM_WR, ibcs_pkg::AS_DIRECT, 2'h0, 1'b0);
	assign wrDirect1 = mk(ibcs_pkg::CY_MEM_WR, ibcs_pkg::AS_DIRECT, 2'h1, 1'b0);
	assign rdPtr     = mk(ibcs_pkg::CY_MEM_RD, ibcs_pkg::AS_PTR, 2'h0, 1'b0);
	assign rdStack   = mk(ibcs_pkg::CY_MEM_RD, ibcs_pkg::AS_STACK, 2'h0, 1'b0);
	assign rdStack1  = mk(ibcs_pkg::CY_MEM_RD, ibcs_pkg::AS_STACK, 2'h1, 1'b0);
	assign wrStackM1 = mk(ibcs_pkg::CY_MEM_WR, ibcs_pkg::AS_STACK, 2'h1, 1'b1);
	assign wrStackM2 = mk(ibcs_pkg::CY_MEM_WR, ibcs_pkg::AS_STACK, 2'h2, 1'b1);

	always_comb begin
		step = DN;
		case (op)
			ibcs_pkg::OP_NOP: begin
				if (index == 4'h0) step = F1;
			end
			ibcs_pkg::OP_NEG, ibcs_pkg::OP_LD_A_VEC: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = F2;
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_LD_A_IND: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = rdPtr;
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_LD_IND_A: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = TI;
					4'h2: step = mk(ibcs_pkg::CY_MEM_WR, ibcs_pkg::AS_PTR, 2'h0, 1'b0);
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_LD_A_MN, ibcs_pkg::OP_LD_MN_A, ibcs_pkg::OP_LD_WW_IMM,
			ibcs_pkg::OP_LD_HL_MN, ibcs_pkg::OP_LD_MN_HL: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = OL;
					4'h2: step = OH;
					4'h3: begin
						if (op == ibcs_pkg::OP_LD_A_MN || op == ibcs_pkg::OP_LD_HL_MN)
							step = rdDirect;
						else if (op != ibcs_pkg::OP_LD_WW_IMM)
							step = TI;
					end
					4'h4: begin
						if (op == ibcs_pkg::OP_LD_HL_MN) step = rdDirect1;
						else if (op == ibcs_pkg::OP_LD_MN_A
							|| op == ibcs_pkg::OP_LD_MN_HL) step = wrDirect;
					end
					4'h5: begin
						if (op == ibcs_pkg::OP_LD_MN_HL) step = wrDirect1;
					end
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_LD_WW_MN_PFX, ibcs_pkg::OP_LD_MN_WW_PFX: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = F2;
					4'h2: step = OL;
					4'h3: step = OH;
					4'h4: step = (op == ibcs_pkg::OP_LD_WW_MN_PFX) ? rdDirect : TI;
					4'h5: step = (op == ibcs_pkg::OP_LD_WW_MN_PFX) ? rdDirect1 : wrDirect;
					4'h6: begin
						if (op == ibcs_pkg::OP_LD_MN_WW_PFX) step = wrDirect1;
					end
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_LD_SP_IDX: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = F2;
					4'h2: step = TI;
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_BLOCK_MOVE, ibcs_pkg::OP_BLOCK_MOVE_REPEAT: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = F2;
					4'h2: step = rdPtr;
					4'h3: step = mk(ibcs_pkg::CY_MEM_WR, ibcs_pkg::AS_DEST, 2'h0, 1'b0);
					4'h4, 4'h5: begin
						if (op == ibcs_pkg::OP_BLOCK_MOVE_REPEAT && !countZero)
							step = TI;
					end
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_BLOCK_OUTPUT, ibcs_pkg::OP_BLOCK_OUTPUT_REPEAT: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = F2;
					4'h2: step = rdPtr;
					4'h3: step = mk(ibcs_pkg::CY_IO_WR, ibcs_pkg::AS_COUNT, 2'h0, 1'b0);
					4'h4, 4'h5: begin
						if (op == ibcs_pkg::OP_BLOCK_OUTPUT_REPEAT && !countZero)
							step = TI;
					end
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_MULTIPLY: begin
				if (index == 4'h0) step = F1;
				else if (index == 4'h1) step = F2;
				else if (index < 4'h2 + `IBCS_MULT_INTERNAL) step = TI;
			end
			ibcs_pkg::OP_OUT_IMM, ibcs_pkg::OP_OUT_C: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = (op == ibcs_pkg::OP_OUT_IMM) ? OL : F2;
					4'h2: step = TI;
					4'h3: step = mk(ibcs_pkg::CY_IO_WR, ibcs_pkg::AS_COUNT, 2'h0, 1'b0);
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_PAGE_ZERO_OUTPUT: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = F2;
					4'h2: step = OL;
					4'h3: step = TI;
					4'h4: step = mk(ibcs_pkg::CY_IO_WR, ibcs_pkg::AS_PZ_IMM, 2'h0, 1'b0);
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_PAGE_ZERO_BLOCK, ibcs_pkg::OP_PAGE_ZERO_BLOCK_REP: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = F2;
					4'h2: step = TI;
					4'h3: step = rdPtr;
					4'h4: step = mk(ibcs_pkg::CY_IO_WR, ibcs_pkg::AS_PZ_C, 2'h0, 1'b0);
					4'h5: step = TI;
					4'h6, 4'h7: begin
						if (op == ibcs_pkg::OP_PAGE_ZERO_BLOCK_REP && !countZero)
							step = TI;
					end
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_POP, ibcs_pkg::OP_RET, ibcs_pkg::OP_POP_IDX,
			ibcs_pkg::OP_RET_INTERRUPT: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = (op == ibcs_pkg::OP_POP || op == ibcs_pkg::OP_RET)
						? rdStack : F2;
					4'h2: step = (op == ibcs_pkg::OP_POP || op == ibcs_pkg::OP_RET)
						? rdStack1 : rdStack;
					4'h3: begin
						if (op == ibcs_pkg::OP_POP_IDX || op == ibcs_pkg::OP_RET_INTERRUPT)
							step = rdStack1;
					end
					default: step = DN;
				endcase
			end
			ibcs_pkg::OP_PUSH, ibcs_pkg::OP_PUSH_IDX: begin
				if (index == 4'h0) step = F1;
				else if (op == ibcs_pkg::OP_PUSH_IDX && index == 4'h1) step = F2;
				else begin
					case (index - ((op == ibcs_pkg::OP_PUSH_IDX) ? 4'h1 : 4'h0))
						4'h1, 4'h2: step = TI;
						4'h3: step = wrStackM1;
						4'h4: step = wrStackM2;
						default: step = DN;
					endcase
				end
			end
			ibcs_pkg::OP_RET_COND: begin
				case (index)
					4'h0: step = F1;
					4'h1: step = TI;
					4'h2: step = condTrue ? rdStack : TI;
					4'h3: step = condTrue ? rdStack1 : DN;
					default: step = DN;
				endcase
			end
			default: step = DN;
		endcase
	end

endmodule

`default_nettype wire
